// ===== hw/sbnt_core.sv
// Behaviour
// - loops return B1 B2 D next to line
// - transparent loop drives line, refuses activation
// - loops started only by c/i commands
// - send 96 kHz or 2 kHz test marks
// - dpll locks bit clock to gci frame
// - fixed rx timing: same corrections, fixed offset
// - adaptive rx timing tracks f-to-l transition
// - internal loop forces adaptive rx timing
// - gci inputs sampled on core clock, c/i taken on dcl rise
// - shutdown idles line, arms detector, stops clock
// - powered down activity pulls gci data low
// - clock distribution held 2 ms after activation
// - line activation accepted during shutdown
// - 192 kbit/s, 48-bit frames, 250 us
// - one is no pulse, zeros alternate
// - frame opens positive F, negative L
// - first zero negative, balance closes group
// - first zero after framing is violation
// - second violation within 13 bits validates
// - position 15 is inverse of FA
// - multiframing ignores violations when FA one
// - sync after three good frames
// - loss after two bad frames
module sbnt_core (
    input  wire logic                core_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                mclk_tick_i,
    input  wire sbnt_pkg::sbnt_gci_t gci_i,
    input  wire logic                line_activity_i,
    input  wire sbnt_pkg::sbnt_sym_t line_rx_i,
    input  wire logic [1:0]          test_signal_pin_i,
    input  wire logic                fixed_timing_i,
    input  wire logic                multiframe_i,
    input  wire logic [47:0]         tx_bits_i,
    output logic                     tx_load_o,
    output sbnt_pkg::sbnt_sym_t      line_tx_o,
    output logic [47:0]              rx_bits_o,
    output logic                     rx_frame_o,
    output logic                     rx_sync_o,
    output logic                     adaptive_o,
    output logic                     clk_dist_en_o,
    output logic                     sig_det_en_o,
    output logic                     gci_dd_o,
    output logic                     gci_dd_oe_n_o
);
    typedef enum logic [1:0] {ST_DOWN, ST_HOLD, ST_ACTIVE, ST_SHUT} sbnt_state_t;

    sbnt_state_t          state;
    sbnt_pkg::sbnt_loop_t loop_mode;
    sbnt_pkg::sbnt_test_t ci_test;
    sbnt_pkg::sbnt_test_t test_sel;
    logic                 dcl_q;
    logic                 fsc_q;
    logic                 ci_take;
    logic                 fsc_rise;
    logic                 act_req;
    logic [4:0]           hold_cnt;
    logic                 running;
    logic [5:0]           tick;
    logic [5:0]           bit_len;
    logic [5:0]           tx_bit;
    logic                 bit_end;
    logic [1:0]           corr;
    logic [47:0]          tx_bits;
    logic                 last_pos;
    logic                 first_zero;
    logic                 parity;
    logic                 cur_bit;
    logic                 fa_cur;
    logic                 fa_prev;
    sbnt_pkg::sbnt_sym_t  next_sym;
    sbnt_pkg::sbnt_sym_t  tx_sym;
    logic                 shut_go;
    sbnt_pkg::sbnt_sym_t  rx_in;
    sbnt_pkg::sbnt_sym_t  rx_in_q;
    logic [5:0]           rx_phase;
    logic                 rx_adj_done;
    logic                 rx_sample;
    logic [5:0]           rx_bit;
    logic [47:0]          rx_shift;
    logic                 rx_last_pos;
    logic                 rx_mark;
    logic                 rx_viol;
    logic                 f_ok;
    logic                 v2_ok;
    logic [1:0]           good_cnt;
    logic [1:0]           bad_cnt;
    logic                 frame_good;

    // c/i strobe qualified by the interface bit clock, frame edge from fsc alone
    assign ci_take  = gci_i.ci_valid && gci_i.dcl && !dcl_q;
    assign fsc_rise = gci_i.fsc && !fsc_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dcl_q <= 1'b0;
            fsc_q <= 1'b0;
        end else begin
            dcl_q <= gci_i.dcl;
            fsc_q <= gci_i.fsc;
        end
    end

    // activation / power-down sequence
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state    <= ST_DOWN;
            hold_cnt <= '0;
            act_req  <= 1'b0;
        end else begin
            unique case (state)
                ST_DOWN: begin
                    if (line_activity_i) begin
                        act_req <= 1'b1;
                    end
                    if (ci_take && gci_i.ci_code == sbnt_pkg::CI_ACTIVATE) begin
                        state    <= ST_HOLD;
                        hold_cnt <= '0;
                        act_req  <= 1'b0;
                    end
                end
                ST_HOLD: begin
                    if (fsc_rise) begin
                        hold_cnt <= hold_cnt + 5'h01;
                    end
                    if (hold_cnt == 5'(sbnt_pkg::HOLD_FRAMES)) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (ci_take && gci_i.ci_code == sbnt_pkg::CI_DEACT) begin
                        state <= ST_SHUT;
                    end
                end
                ST_SHUT: begin
                    state <= ST_DOWN;
                    if (line_activity_i) begin
                        act_req <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign running       = (state == ST_ACTIVE);
    assign shut_go       = running && ci_take && gci_i.ci_code == sbnt_pkg::CI_DEACT;
    assign clk_dist_en_o = (state == ST_ACTIVE) || (state == ST_SHUT);
    assign sig_det_en_o  = (state == ST_DOWN) || (state == ST_SHUT);
    // open-drain data line, pulled low without any gci clock
    assign gci_dd_o      = 1'b0;
    assign gci_dd_oe_n_o = !(act_req || (sig_det_en_o && line_activity_i));

    // loop and test selection from c/i commands
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            loop_mode <= sbnt_pkg::SBNT_LOOP_NONE;
            ci_test   <= sbnt_pkg::SBNT_TEST_NONE;
        end else if (state == ST_DOWN) begin
            loop_mode <= sbnt_pkg::SBNT_LOOP_NONE;
            ci_test   <= sbnt_pkg::SBNT_TEST_NONE;
        end else if (ci_take) begin
            unique case (gci_i.ci_code)
                sbnt_pkg::CI_LOOP_INT: loop_mode <= sbnt_pkg::SBNT_LOOP_INT;
                sbnt_pkg::CI_LOOP_TRN: loop_mode <= sbnt_pkg::SBNT_LOOP_TRN;
                sbnt_pkg::CI_SSZ:      ci_test   <= sbnt_pkg::SBNT_TEST_SSZ;
                sbnt_pkg::CI_SCZ:      ci_test   <= sbnt_pkg::SBNT_TEST_SCZ;
                sbnt_pkg::CI_NORMAL: begin
                    loop_mode <= sbnt_pkg::SBNT_LOOP_NONE;
                    ci_test   <= sbnt_pkg::SBNT_TEST_NONE;
                end
                default: ;
            endcase
        end
    end

    // pin overrides c/i for line tests
    always_comb begin
        if (test_signal_pin_i[1]) begin
            test_sel = sbnt_pkg::SBNT_TEST_SCZ;
        end else if (test_signal_pin_i[0]) begin
            test_sel = sbnt_pkg::SBNT_TEST_SSZ;
        end else begin
            test_sel = ci_test;
        end
    end

    // bit clock: 40 master ticks per bit, one tick slipped per frame
    assign bit_end = mclk_tick_i && (tick == bit_len - 6'h01);

    always_comb begin
        bit_len = 6'(sbnt_pkg::TICKS_PER_BIT);
        if (tx_bit == 6'(sbnt_pkg::FRAME_BITS - 1)) begin
            if (corr[1]) begin
                bit_len = 6'(sbnt_pkg::TICKS_PER_BIT + sbnt_pkg::DPLL_STEP);
            end else if (corr[0]) begin
                bit_len = 6'(sbnt_pkg::TICKS_PER_BIT - sbnt_pkg::DPLL_STEP);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !running) begin
            tick   <= '0;
            tx_bit <= '0;
        end else if (bit_end) begin
            tick   <= '0;
            tx_bit <= (tx_bit == 6'(sbnt_pkg::FRAME_BITS - 1)) ? 6'h00 : tx_bit + 6'h01;
        end else if (mclk_tick_i) begin
            tick <= tick + 6'h01;
        end
    end

    // phase detector: line frame start against gci frame edge
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !running) begin
            corr <= 2'b00;
        end else if (bit_end && tx_bit == 6'(sbnt_pkg::FRAME_BITS - 1)) begin
            corr <= 2'b00;
        end else if (fsc_rise && (tx_bit != '0 || tick != '0)) begin
            if (tx_bit < 6'(sbnt_pkg::FRAME_BITS / 4)
                || (tx_bit >= 6'(sbnt_pkg::FRAME_BITS / 2)
                    && tx_bit < 6'(3 * sbnt_pkg::FRAME_BITS / 4))) begin
                corr <= 2'b10;
            end else begin
                corr <= 2'b01;
            end
        end
    end

    // frame content with framing, flag and inverse flag forced
    always_comb begin
        cur_bit = tx_bits[tx_bit];
        if (tx_bit == 6'(sbnt_pkg::POS_F) || tx_bit == 6'(sbnt_pkg::POS_L_FRAME)) begin
            cur_bit = 1'b0;
        end else if (tx_bit == 6'(sbnt_pkg::POS_FA)) begin
            cur_bit = fa_cur;
        end else if (tx_bit == 6'(sbnt_pkg::POS_N)) begin
            cur_bit = !fa_cur;
        end else if (tx_bit == 6'(sbnt_pkg::POS_L_LAST)) begin
            cur_bit = !parity;
        end
    end

    // ami symbol for the current bit
    always_comb begin
        next_sym = '0;
        unique case (test_sel)
            sbnt_pkg::SBNT_TEST_SCZ: begin
                next_sym.pos = !last_pos;
                next_sym.neg = last_pos;
            end
            sbnt_pkg::SBNT_TEST_SSZ: begin
                if (tx_bit == 6'(sbnt_pkg::SSZ_BIT)) begin
                    next_sym.pos = !last_pos;
                    next_sym.neg = last_pos;
                end
            end
            sbnt_pkg::SBNT_TEST_NONE: begin
                if (tx_bit == 6'(sbnt_pkg::POS_F)) begin
                    next_sym.pos = 1'b1;
                end else if (tx_bit == 6'(sbnt_pkg::POS_L_FRAME)) begin
                    next_sym.neg = 1'b1;
                end else if (!cur_bit) begin
                    next_sym.pos = !first_zero && !last_pos;
                    next_sym.neg = first_zero || last_pos;
                end
            end
            default: ;
        endcase
    end

    // line coder state, output register and frame load
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !running || shut_go) begin
            line_tx_o  <= '0;
            tx_sym     <= '0;
            last_pos   <= 1'b1;
            first_zero <= 1'b0;
            parity     <= 1'b0;
            tx_bits    <= '1;
            fa_cur     <= 1'b0;
            fa_prev    <= 1'b0;
        end else if (mclk_tick_i && tick == '0) begin
            if (loop_mode == sbnt_pkg::SBNT_LOOP_INT) begin
                line_tx_o <= '0;
            end else begin
                line_tx_o <= next_sym;
            end
            tx_sym <= next_sym;
            if (next_sym.pos || next_sym.neg) begin
                last_pos <= next_sym.pos;
            end
            if (tx_bit == 6'(sbnt_pkg::POS_L_FRAME)) begin
                first_zero <= 1'b1;
                parity     <= 1'b0;
            end else if (!cur_bit && tx_bit < 6'(sbnt_pkg::POS_L_LAST)) begin
                first_zero <= 1'b0;
                parity     <= !parity;
            end
            if (tx_bit == 6'(sbnt_pkg::POS_L_LAST)) begin
                tx_bits <= tx_bits_i;
                fa_prev <= fa_cur;
                fa_cur  <= multiframe_i && tx_bits_i[sbnt_pkg::POS_FA];
            end
        end
    end

    assign tx_load_o = running && mclk_tick_i && tick == '0
                       && tx_bit == 6'(sbnt_pkg::POS_L_LAST);

    // receive input: loop taken right at the line side
    assign rx_in      = (loop_mode != sbnt_pkg::SBNT_LOOP_NONE) ? tx_sym : line_rx_i;
    assign adaptive_o = !fixed_timing_i || loop_mode != sbnt_pkg::SBNT_LOOP_NONE;
    assign rx_sample  = running && mclk_tick_i
                        && tick == (adaptive_o ? rx_phase : 6'(sbnt_pkg::RX_FIX_TICK));

    // adaptive sampling phase: centre on the f-to-l edge, one step per frame
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !running) begin
            rx_in_q     <= '0;
            rx_phase    <= 6'(sbnt_pkg::RX_FIX_TICK);
            rx_adj_done <= 1'b0;
        end else begin
            if (mclk_tick_i) begin
                rx_in_q <= rx_in;
            end
            if (bit_end && tx_bit == 6'(sbnt_pkg::FRAME_BITS - 1)) begin
                rx_adj_done <= 1'b0;
            end else if (adaptive_o && mclk_tick_i && rx_in.neg && rx_in_q.pos
                         && !rx_adj_done) begin
                rx_adj_done <= 1'b1;
                if (tick < 6'(sbnt_pkg::RX_MID_OFFSET)) begin
                    if (rx_phase != tick + 6'(sbnt_pkg::RX_MID_OFFSET)) begin
                        rx_phase <= (rx_phase < tick + 6'(sbnt_pkg::RX_MID_OFFSET))
                                    ? rx_phase + 6'h01 : rx_phase - 6'h01;
                    end
                end else if (rx_phase != tick - 6'(sbnt_pkg::RX_MID_OFFSET)) begin
                    rx_phase <= (rx_phase < tick - 6'(sbnt_pkg::RX_MID_OFFSET))
                                ? rx_phase + 6'h01 : rx_phase - 6'h01;
                end
            end
        end
    end

    // violation detection on sampled symbols
    assign rx_mark = rx_in.pos || rx_in.neg;
    assign rx_viol = rx_mark && (rx_in.pos == rx_last_pos);

    // frame verdict with multiframing exceptions
    always_comb begin
        frame_good = (f_ok || (multiframe_i && fa_prev))
                     && (v2_ok || (multiframe_i && fa_cur));
    end

    // frame sync, counters and received data
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !running) begin
            rx_bit      <= 6'(sbnt_pkg::FRAME_BITS - sbnt_pkg::UPLINK_LAG);
            rx_shift    <= '1;
            rx_bits_o   <= '1;
            rx_frame_o  <= 1'b0;
            rx_last_pos <= 1'b0;
            f_ok        <= 1'b0;
            v2_ok       <= 1'b0;
            good_cnt    <= '0;
            bad_cnt     <= '0;
            rx_sync_o   <= 1'b0;
        end else begin
            rx_frame_o <= 1'b0;
            if (rx_sample) begin
                if (rx_mark) begin
                    rx_last_pos <= rx_in.pos;
                end
                rx_shift <= {!rx_mark, rx_shift[47:1]};
                if (!rx_sync_o && rx_viol && rx_in.pos) begin
                    rx_bit <= 6'h01; // hunt: realign on positive violation
                    f_ok   <= 1'b1;
                    v2_ok  <= 1'b0;
                end else if (rx_bit == 6'(sbnt_pkg::FRAME_BITS - 1)) begin
                    rx_bit     <= '0;
                    rx_bits_o  <= {!rx_mark, rx_shift[47:1]};
                    rx_frame_o <= 1'b1;
                    if (frame_good) begin
                        bad_cnt <= '0;
                        if (good_cnt == 2'(sbnt_pkg::SYNC_FRAMES - 1)) begin
                            rx_sync_o <= 1'b1;
                        end else begin
                            good_cnt <= good_cnt + 2'h1;
                        end
                    end else begin
                        good_cnt <= '0;
                        if (bad_cnt == 2'(sbnt_pkg::LOSS_FRAMES - 1)) begin
                            rx_sync_o <= 1'b0;
                            bad_cnt   <= '0;
                        end else begin
                            bad_cnt <= bad_cnt + 2'h1;
                        end
                    end
                end else begin
                    rx_bit <= rx_bit + 6'h01;
                    if (rx_bit == 6'(sbnt_pkg::POS_F)) begin
                        f_ok  <= rx_viol && rx_in.pos;
                        v2_ok <= 1'b0;
                    end else if (rx_viol && rx_bit <= 6'(sbnt_pkg::V2_LIMIT + 1)) begin
                        v2_ok <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : sbnt_core

// ===== pkg/sbnt_pkg.sv
package sbnt_pkg;
    // line frame layout
    localparam int unsigned FRAME_BITS     = 48;
    localparam int unsigned POS_F          = 0;
    localparam int unsigned POS_L_FRAME    = 1;
    localparam int unsigned POS_FA         = 14;
    localparam int unsigned POS_N          = 15;
    localparam int unsigned POS_L_LAST     = 47;
    localparam int unsigned V2_LIMIT       = 13;
    localparam int unsigned SYNC_FRAMES    = 3;
    localparam int unsigned LOSS_FRAMES    = 2;
    localparam int unsigned UPLINK_LAG     = 2;
    // master clock ticks per 192 kHz bit, dpll step in ticks
    localparam int unsigned TICKS_PER_BIT  = 40;
    localparam int unsigned DPLL_STEP      = 1;
    localparam int unsigned RX_ADVANCE     = 5;
    localparam int unsigned RX_FIX_TICK    = TICKS_PER_BIT - RX_ADVANCE;
    localparam int unsigned RX_MID_OFFSET  = TICKS_PER_BIT / 2;
    // clock hold-off after activation, timed in gci frames
    localparam int unsigned HOLD_US        = 2000;
    localparam int unsigned GCI_FRAME_US   = 125;
    localparam int unsigned HOLD_FRAMES    = HOLD_US / GCI_FRAME_US;
    // 2 kHz single marks: one mark per line frame
    localparam int unsigned SSZ_BIT        = 0;
    // command codes on the c/i channel
    localparam logic [3:0] CI_NORMAL   = 4'h0;
    localparam logic [3:0] CI_ACTIVATE = 4'h8;
    localparam logic [3:0] CI_DEACT    = 4'hf;
    localparam logic [3:0] CI_SSZ      = 4'h2;
    localparam logic [3:0] CI_SCZ      = 4'h3;
    localparam logic [3:0] CI_LOOP_INT = 4'ha;
    localparam logic [3:0] CI_LOOP_TRN = 4'hb;

    typedef enum logic [1:0] {SBNT_LOOP_NONE, SBNT_LOOP_INT, SBNT_LOOP_TRN} sbnt_loop_t;
    typedef enum logic [1:0] {SBNT_TEST_NONE, SBNT_TEST_SSZ, SBNT_TEST_SCZ} sbnt_test_t;

    // ternary line symbol
    typedef struct packed {
        logic pos;
        logic neg;
    } sbnt_sym_t;

    // gci side inputs sampled on core clock
    typedef struct packed {
        logic       dcl;
        logic       fsc;
        logic       ci_valid;
        logic [3:0] ci_code;
    } sbnt_gci_t;
endpackage : sbnt_pkg

// ===== tb/sbnt_checker.sv
module sbnt_checker (
    input wire logic                core_clk_i,
    input wire logic                sys_rst_i,
    input wire logic                line_activity_i,
    input wire logic                fixed_timing_i,
    input wire logic                tx_load_o,
    input wire sbnt_pkg::sbnt_sym_t line_tx_o,
    input wire logic                rx_frame_o,
    input wire logic                rx_sync_o,
    input wire logic                adaptive_o,
    input wire logic                clk_dist_en_o,
    input wire logic                gci_dd_o,
    input wire logic                gci_dd_oe_n_o,
    input wire logic                sig_det_en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // idle, unsynced and clock off right after reset
    a_reset_leaves_idle: assert property (
        $fell(sys_rst_i) |-> line_tx_o == '0 && !rx_sync_o && !clk_dist_en_o)
        else $error("not idle after reset");
    a_sym_one_polarity: assert property (!(line_tx_o.pos && line_tx_o.neg))
        else $error("both polarities at once");
    a_dd_pulls_low: assert property (gci_dd_o == 1'h0)
        else $error("gci data driven high");
    a_activity_requests: assert property (
        line_activity_i && sig_det_en_o && !clk_dist_en_o |-> !gci_dd_oe_n_o)
        else $error("activity without request");
    a_clock_stop_order: assert property (
        $fell(clk_dist_en_o) |-> $past(sig_det_en_o) && $past(line_tx_o) == '0)
        else $error("clock stopped before idle and detector");
    a_adaptive_free: assert property (!fixed_timing_i |-> adaptive_o)
        else $error("adaptive timing not used");
    a_rx_frame_pulse: assert property (rx_frame_o |=> !rx_frame_o [*8])
        else $error("rx frame pulse too long");
    a_tx_load_pulse: assert property (tx_load_o |=> !tx_load_o [*8])
        else $error("tx load pulse too long");
    c_sync: cover property ($rose(rx_sync_o));
    c_active: cover property ($rose(clk_dist_en_o));
    c_request: cover property ($fell(gci_dd_oe_n_o));
endmodule : sbnt_checker

bind sbnt_core sbnt_checker sbnt_checker_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .line_activity_i(line_activity_i),
    .fixed_timing_i(fixed_timing_i), .tx_load_o(tx_load_o), .line_tx_o(line_tx_o),
    .rx_frame_o(rx_frame_o), .rx_sync_o(rx_sync_o), .adaptive_o(adaptive_o),
    .clk_dist_en_o(clk_dist_en_o), .gci_dd_o(gci_dd_o), .gci_dd_oe_n_o(gci_dd_oe_n_o),
    .sig_det_en_o(sig_det_en_o)
);

// ===== tb/sbnt_term_model.sv
module sbnt_term_model (
    input  wire logic                core_clk_i,
    input  wire sbnt_pkg::sbnt_sym_t nt_tx_i,
    input  wire logic                talk_i,
    output sbnt_pkg::sbnt_sym_t      te_tx_o
);
    timeunit 1ns;
    timeprecision 100ps;
    sbnt_pkg::sbnt_sym_t dly [160];
    // terminal answers two bits behind the downlink frame, same group balancing
    always_ff @(posedge core_clk_i) begin
        dly[0] <= nt_tx_i;
        for (int k = 1; k < 160; k++) begin
            dly[k] <= dly[k-1];
        end
    end
    // a silent terminal leaves the line at no signal
    assign te_tx_o = talk_i ? dly[159] : '0;
endmodule : sbnt_term_model

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk  = 1'h0;
    logic                rst  = 1'h1;
    logic                tick = 1'h0;
    logic                gon  = 1'h0;
    logic                civ  = 1'h0;
    logic [3:0]          cic  = 4'h0;
    logic [4:0]          dcnt = 5'h00;
    logic [5:0]          bcnt = 6'h00;
    logic                act  = 1'h0;
    logic                talk = 1'h0;
    logic [1:0]          test_signal_pin  = 2'h0;
    logic                fix  = 1'h0;
    logic [47:0]         p, q;
    logic [47:0]         rxb;
    int                  checks = 0;
    int                  mismatches = 0;
    sbnt_pkg::sbnt_gci_t gci;
    sbnt_pkg::sbnt_sym_t ltx, lrx;
    logic                rxs, adp, cde, sde, ddo, oen;

    initial begin
        forever begin
            #12.5 clk = !clk;
        end
    end
    // gci master supplies bit clock, frame and master tick once asked
    always_ff @(posedge clk) begin
        tick <= gon && !tick;
        if (gon) begin
            dcnt <= (dcnt == 5'h1d) ? 5'h00 : dcnt + 5'h01;
            if (dcnt == 5'h1d) begin
                bcnt <= bcnt + 6'h01;
            end
        end
    end
    assign gci = {gon && dcnt < 5'h0f, gon && bcnt == 6'h00, civ, cic};

    sbnt_core sbnt_core_i (
        .core_clk_i(clk), .sys_rst_i(rst), .mclk_tick_i(tick), .gci_i(gci),
        .line_activity_i(act), .line_rx_i(lrx), .test_signal_pin_i(test_signal_pin),
        .fixed_timing_i(fix), .multiframe_i(1'h0), .tx_bits_i(48'hffff_ffff_ffff),
        .tx_load_o(), .line_tx_o(ltx), .rx_bits_o(rxb), .rx_frame_o(), .rx_sync_o(rxs),
        .adaptive_o(adp), .clk_dist_en_o(cde), .sig_det_en_o(sde), .gci_dd_o(ddo),
        .gci_dd_oe_n_o(oen)
    );
    sbnt_term_model sbnt_term_model_i (
        .core_clk_i(clk), .nt_tx_i(ltx), .talk_i(talk), .te_tx_o(lrx)
    );

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    function automatic logic probe(input int s);
        case (s)
            0: return cde;
            1: return rxs;
            2: return gci.dcl;
            3: return ltx.pos;
            5: return ltx.pos || ltx.neg;
            default: return ltx.neg;
        endcase
    endfunction : probe
    // bounded wait; running out ends the run
    task automatic wait_on(input string what, input int s, input logic v, input int lim);
        for (int n = 0; n < lim && probe(s) !== v; n++) begin
            @(posedge clk);
        end
        if (probe(s) !== v) begin
            check(what, 1'h0, 1'h1);
            complete_run();
        end
    endtask : wait_on
    // command taken on the dcl rising edge, then one dcl period of spacing
    task automatic send_ci(input logic [3:0] code);
        @(posedge clk);
        civ <= 1'h1;
        cic <= code;
        wait_on("dcl low", 2, 1'h0, 40);
        wait_on("dcl high", 2, 1'h1, 40);
        repeat (3) @(posedge clk);
        civ <= 1'h0;
        repeat (30) @(posedge clk);
    endtask : send_ci
    // one symbol per bit, sampled mid bit (80 core cycles a bit)
    task automatic grab();
        for (int i = 0; i < 48; i++) begin
            p[i] = ltx.pos;
            q[i] = ltx.neg;
            repeat (80) @(posedge clk);
        end
    endtask : grab
    task automatic t_activate();
        int n;
        check("idle line", ltx, 2'h0);
        check("clock off", cde, 1'h0);
        check("detector on", sde, 1'h1);
        act <= 1'h1;
        repeat (2) @(posedge clk);
        check("request", oen, 1'h0);
        act <= 1'h0;
        repeat (2) @(posedge clk);
        check("request held", oen, 1'h0);
        gon <= 1'h1;
        repeat (100) @(posedge clk);
        send_ci(sbnt_pkg::CI_ACTIVATE);
        for (n = 0; n < 40000 && cde !== 1'h1; n++) begin
            @(posedge clk);
        end
        check("hold off", n >= 15 * 1920 && n <= 17 * 1920, 1'h1);
        check("request cleared", oen, 1'h1);
        $display("activation done");
    endtask : t_activate
    task automatic t_frame();
        wait_on("f mark", 3, 1'h1, 8000);
        wait_on("l mark", 4, 1'h1, 200);
        repeat (40) @(posedge clk);
        grab();
        check("neg marks", q, 48'h0000_0000_2001);
        check("pos marks", p, 48'hc000_0000_0000);
        $display("frame done");
    endtask : t_frame
    task automatic t_sync();
        talk <= 1'h1;
        repeat (3840) @(posedge clk);
        check("early sync", rxs, 1'h0);
        wait_on("sync", 1, 1'h1, 16000);
        check("sync", rxs, 1'h1);
        check("rx frame", rxb, 48'h7fff_ffff_bffc);
        talk <= 1'h0;
        repeat (3000) @(posedge clk);
        check("sync kept", rxs, 1'h1);
        wait_on("loss", 1, 1'h0, 9000);
        check("loss", rxs, 1'h0);
        $display("sync done");
    endtask : t_sync
    task automatic t_loops();
        fix <= 1'h1;
        repeat (2) @(posedge clk);
        check("fixed timing", adp, 1'h0);
        send_ci(sbnt_pkg::CI_LOOP_INT);
        check("loop adaptive", adp, 1'h1);
        repeat (80) @(posedge clk);
        grab();
        check("loop line idle", p | q, 48'h0);
        wait_on("loop sync", 1, 1'h1, 16000);
        send_ci(sbnt_pkg::CI_LOOP_TRN);
        repeat (80) @(posedge clk);
        grab();
        check("trn line driven", |(p | q), 1'h1);
        act <= 1'h1;
        repeat (2) @(posedge clk);
        check("trn refuses", oen, 1'h1);
        act <= 1'h0;
        send_ci(sbnt_pkg::CI_NORMAL);
        fix <= 1'h0;
        $display("loops done");
    endtask : t_loops
    task automatic t_tests();
        send_ci(sbnt_pkg::CI_SSZ);
        repeat (80) @(posedge clk);
        wait_on("ssz mark", 5, 1'h1, 8000);
        repeat (40) @(posedge clk);
        grab();
        check("single marks", $countones(p | q), 48'h1);
        send_ci(sbnt_pkg::CI_NORMAL);
        test_signal_pin <= 2'h2;
        repeat (80) @(posedge clk);
        wait_on("scz mark", 3, 1'h1, 400);
        repeat (40) @(posedge clk);
        grab();
        check("continuous", p | q, 48'hffff_ffff_ffff);
        check("alternating", $countones(p), 48'h18);
        test_signal_pin <= 2'h0;
        $display("tests done");
    endtask : t_tests
    task automatic t_deact();
        act <= 1'h1;
        send_ci(sbnt_pkg::CI_DEACT);
        check("clock stopped", cde, 1'h0);
        check("line idle", ltx, 2'h0);
        check("shut activation", oen, 1'h0);
        $display("deactivation done");
    endtask : t_deact

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_activate();
        t_frame();
        t_sync();
        t_loops();
        t_tests();
        t_deact();
        complete_run();
    end
endmodule : tb
